// ---- design/sfc_status.sv ----
`timescale 1ns/1ps
// Behaviour
// - Status byte: ready bit 7, compare mismatch bit 6, density code 5..3.
// - Reset pin low aborts the running operation and idles the logic.
// - Reset holds while the pin stays low; operation resumes after it rises.
// - Power-on reset is internal; the reset pin needs no power-on sequence.
// - Open-drain ready/busy pin is driven low only during self-timed work.
// - Busy covers programming, compare and page-to-buffer transfer.
// - While busy, array and active buffer are blocked; other buffer is free.
// - After reset the clock mode is 3 and the serial output floats.
// - No instruction is taken until chip select falls after reset.
// - Each chip select fall samples idle clock level: low mode 0, high 3.
// - Serial input bits are captured on the rising clock edge.
// - Transfer or compare ends within 250 us, typically 120 us.
// - Erase-program ends within 20 ms; program-only within 14 ms.
// - Ready bit is one when idle, zero while busy.
// - Compare bit clears on a matching compare and sets on any mismatch.
// - Opcode 57H streams the status byte MSB first, repeating while selected.
module sfc_status #(
   parameter int unsigned XFER_CYC = sfc_pkg::XFER_CYC,
   parameter int unsigned EP_CYC = sfc_pkg::EP_CYC,
   parameter int unsigned P_CYC = sfc_pkg::P_CYC,
   // Arbitrary neutral density code; set per product.
   parameter logic [sfc_pkg::DENS_W-1:0] DENSITY_CODE = 3'h5
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic RESET_N,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   output logic SO_O,
   output logic SO_OE,
   output logic RDY_N_O,
   output logic RDY_N_OE,
   input wire logic OP_START,
   input wire sfc_pkg::sfc_op_e OP_KIND,
   input wire logic OP_BUF,
   input wire logic CMP_MISMATCH,
   output logic OP_ACCEPT,
   output logic ARRAY_BLOCK,
   output logic [1:0] BUF_BLOCK,
   output logic MODE3,
   output logic [7:0] STATUS_BYTE
);
   typedef enum {S_UNARMED, S_DESEL, S_CMD, S_STAT, S_OTHER} sfc_sstate_e;

   logic [3:0] pin_raw;
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic rst_int;

   sfc_op_if op ();

   // Two flops per pin; only the second stage feeds any logic.
   assign pin_raw = {RESET_N, SI, SCK, CS_N};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge MCLK) begin
            if (RST) begin
               pin_meta[gi] <= sfc_pkg::PIN_IDLE[gi];
               pin_sync[gi] <= sfc_pkg::PIN_IDLE[gi];
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   assign cs_s = pin_sync[sfc_pkg::PIN_CS];
   assign sck_s = pin_sync[sfc_pkg::PIN_SCK];
   assign si_s = pin_sync[sfc_pkg::PIN_SI];
   // The pin reset is level sensitive, so it holds everything for as long
   // as it stays low and releases on the first cycle it reads high.
   assign rst_int = RST | ~pin_sync[sfc_pkg::PIN_RST];

   // Self-timed operation control.
   sfc_pkg::sfc_op_e cur_kind;
   sfc_pkg::sfc_op_e next_kind;
   logic cur_buf;
   logic next_buf;
   logic comp;
   logic next_comp;
   logic [1:0] blk;
   logic [1:0] next_blk;
   logic accept;

   // A start while busy is dropped rather than queued.
   assign accept = OP_START & ~op.busy;
   assign op.start = accept;
   assign op.kind = OP_KIND;

   always_comb begin
      next_kind = cur_kind;
      next_buf = cur_buf;
      next_comp = comp;
      next_blk = blk;
      if (accept) begin
         next_kind = OP_KIND;
         next_buf = OP_BUF;
         next_blk = OP_BUF ? 2'h2 : 2'h1;
      end else if (op.done) begin
         next_blk = 2'h0;
         if (cur_kind == sfc_pkg::OP_CMP) begin
            next_comp = CMP_MISMATCH;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (rst_int) begin
         cur_kind <= sfc_pkg::OP_XFER;
         cur_buf <= 1'b0;
         comp <= sfc_pkg::COMP_RST;
         blk <= 2'h0;
      end else begin
         cur_kind <= next_kind;
         cur_buf <= next_buf;
         comp <= next_comp;
         blk <= next_blk;
      end
   end

   sfc_op_timer #(
      .XFER_CYC(XFER_CYC),
      .EP_CYC(EP_CYC),
      .P_CYC(P_CYC)
   ) u_timer (
      .clk(MCLK),
      .rst(rst_int),
      .op(op.tmr)
   );

   // Serial side: edges are found on the synchronised pins.
   sfc_sstate_e state;
   sfc_sstate_e next_state;
   logic cs_q;
   logic sck_q;
   logic mode3;
   logic next_mode3;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic [7:0] sh_in;
   logic [2:0] bitcnt;
   logic [2:0] next_bitcnt;
   logic [2:0] stidx;
   logic [2:0] next_stidx;
   logic so_d;
   logic next_so_d;
   logic so_oe;
   logic next_so_oe;
   logic [7:0] status;
   logic [7:0] next_status;
   logic cs_fall;
   logic sck_rise;
   logic sck_fall;

   assign cs_fall = cs_q & ~cs_s;
   assign sck_rise = ~sck_q & sck_s;
   assign sck_fall = sck_q & ~sck_s;
   assign sh_in = {sh[6:0], si_s};

   always_comb begin
      next_status = {~op.busy, comp, DENSITY_CODE,
                     sfc_pkg::RSVD_VAL};
      next_state = state;
      next_mode3 = mode3;
      next_sh = sh;
      next_bitcnt = bitcnt;
      next_stidx = stidx;
      next_so_d = so_d;
      next_so_oe = so_oe;
      if (cs_fall) begin
         next_mode3 = sck_s;
         next_state = S_CMD;
         next_bitcnt = 3'h0;
         next_so_oe = 1'b0;
      end else if (cs_s) begin
         next_so_oe = 1'b0;
         if (state != S_UNARMED) begin
            next_state = S_DESEL;
         end
      end else begin
         case (state)
            S_CMD: begin
               if (sck_rise) begin
                  next_sh = sh_in;
                  next_bitcnt = bitcnt + 3'h1;
                  if (bitcnt == sfc_pkg::BIT_LAST) begin
                     if (sh_in == sfc_pkg::OPC_STATUS) begin
                        next_state = S_STAT;
                        next_stidx = sfc_pkg::BIT_LAST;
                     end else begin
                        next_state = S_OTHER;
                     end
                  end
               end
            end
            S_STAT: begin
               // Shifting on the falling edge suits both clock modes.
               if (sck_fall) begin
                  next_so_d = status[stidx];
                  next_so_oe = 1'b1;
                  next_stidx = stidx - 3'h1;
               end
            end
            S_UNARMED, S_DESEL, S_OTHER: begin
               next_so_oe = so_oe;
            end
            default: next_state = S_UNARMED;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (rst_int) begin
         state <= S_UNARMED;
         // The edge history tracks the pins through reset, so a select
         // held low across a pin reset is never taken for a fresh fall.
         cs_q <= cs_s;
         sck_q <= sck_s;
         mode3 <= sfc_pkg::MODE3_RST;
         sh <= 8'h00;
         bitcnt <= 3'h0;
         stidx <= sfc_pkg::BIT_LAST;
         so_d <= 1'b0;
         so_oe <= 1'b0;
         status <= 8'h00;
      end else begin
         state <= next_state;
         cs_q <= cs_s;
         sck_q <= sck_s;
         mode3 <= next_mode3;
         sh <= next_sh;
         bitcnt <= next_bitcnt;
         stidx <= next_stidx;
         so_d <= next_so_d;
         so_oe <= next_so_oe;
         status <= next_status;
      end
   end

   assign SO_O = so_d;
   assign SO_OE = so_oe;
   assign RDY_N_O = 1'b0;
   assign RDY_N_OE = op.busy;
   assign OP_ACCEPT = accept;
   assign ARRAY_BLOCK = op.busy;
   assign BUF_BLOCK = blk;
   assign MODE3 = mode3;
   assign STATUS_BYTE = status;
endmodule : sfc_status

// ---- design/sfc_pkg.sv ----
package sfc_pkg;
   // Core clock rate and self-timed operation durations.
   localparam int CLK_MHZ = 200;
   localparam int XFER_TYP_US = 120;
   localparam int XFER_MAX_US = 250;
   localparam int EP_TYP_MS = 10;
   localparam int EP_MAX_MS = 20;
   localparam int P_TYP_MS = 7;
   localparam int P_MAX_MS = 14;
   localparam int XFER_CYC = XFER_TYP_US * CLK_MHZ;
   localparam int EP_CYC = EP_TYP_MS * 1000 * CLK_MHZ;
   localparam int P_CYC = P_TYP_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 22;

   // Serial command and status byte layout.
   localparam logic [7:0] OPC_STATUS = 8'h57;
   localparam int RDY_BIT = 7;
   localparam int COMP_BIT = 6;
   localparam int DENS_LSB = 3;
   localparam int DENS_W = 3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] RSVD_VAL = 3'h0;

   // Reset values and pin bit positions.
   localparam logic MODE3_RST = 1'b1;
   localparam logic COMP_RST = 1'b0;
   localparam logic [3:0] PIN_IDLE = 4'hF;
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_RST = 3;

   typedef enum logic [1:0] {OP_XFER, OP_CMP, OP_ERPG, OP_PROG} sfc_op_e;
endpackage : sfc_pkg

// ---- design/sfc_op_if.sv ----
`timescale 1ns/1ps
interface sfc_op_if;
   logic start;
   sfc_pkg::sfc_op_e kind;
   logic busy;
   logic done;
   modport ctl (output start, output kind, input busy, input done);
   modport tmr (input start, input kind, output busy, output done);
endinterface : sfc_op_if

// ---- design/sfc_op_timer.sv ----
`timescale 1ns/1ps
module sfc_op_timer #(
   parameter int unsigned XFER_CYC = sfc_pkg::XFER_CYC,
   parameter int unsigned EP_CYC = sfc_pkg::EP_CYC,
   parameter int unsigned P_CYC = sfc_pkg::P_CYC
) (
   input wire logic clk,
   input wire logic rst,
   sfc_op_if.tmr op
);
   typedef enum {T_IDLE, T_RUN} sfc_tstate_e;

   sfc_tstate_e state;
   sfc_tstate_e next_state;
   logic [sfc_pkg::CNT_W-1:0] cnt;
   logic [sfc_pkg::CNT_W-1:0] next_cnt;

   function automatic logic [sfc_pkg::CNT_W-1:0] load_of(
      sfc_pkg::sfc_op_e k);
      case (k)
         sfc_pkg::OP_ERPG: load_of = sfc_pkg::CNT_W'(EP_CYC - 1);
         sfc_pkg::OP_PROG: load_of = sfc_pkg::CNT_W'(P_CYC - 1);
         default: load_of = sfc_pkg::CNT_W'(XFER_CYC - 1);
      endcase
   endfunction : load_of

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         T_IDLE: begin
            if (op.start) begin
               next_state = T_RUN;
               next_cnt = load_of(op.kind);
            end
         end
         T_RUN: begin
            if (cnt == '0) begin
               next_state = T_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         default: next_state = T_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= T_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign op.busy = (state == T_RUN);
   assign op.done = (state == T_RUN) && (cnt == '0);
endmodule : sfc_op_timer

// ---- verification/sfc_status_monitor.sv ----
`timescale 1ns/1ps
module sfc_status_monitor #(
   parameter int unsigned XFER_CYC = 20,
   parameter int unsigned EP_CYC = 60,
   parameter int unsigned P_CYC = 40,
   parameter logic [2:0] DENSITY_CODE = 3'h5
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic RESET_N,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic RDY_N_OE,
   input wire logic OP_START,
   input wire sfc_pkg::sfc_op_e OP_KIND,
   input wire logic OP_BUF,
   input wire logic CMP_MISMATCH,
   input wire logic OP_ACCEPT,
   input wire logic ARRAY_BLOCK,
   input wire logic [1:0] BUF_BLOCK,
   input wire logic MODE3,
   input wire logic [7:0] STATUS_BYTE
);
   // The pin reset is synchronised, so checks wait for it to settle.
   logic [2:0] calm;
   logic [21:0] bcnt;
   sfc_pkg::sfc_op_e kq;
   int unsigned elen;
   always_ff @(posedge MCLK) begin
      calm <= (RST || !RESET_N) ? 3'h0 : (calm == 3'h7) ? calm : calm + 3'h1;
      bcnt <= RDY_N_OE ? bcnt + 22'h1 : 22'h0;
      if (OP_ACCEPT) kq <= OP_KIND;
   end
   assign elen = (kq == sfc_pkg::OP_ERPG) ? EP_CYC :
      (kq == sfc_pkg::OP_PROG) ? P_CYC : XFER_CYC;
   sequence s_take;
      OP_ACCEPT && calm == 3'h7;
   endsequence
   sequence s_done;
      $fell(RDY_N_OE) && calm == 3'h7;
   endsequence
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_accept_gate: assert property (
      OP_ACCEPT == (OP_START && !RDY_N_OE)) else $error("bad accept");
   a_busy_start: assert property (
      s_take |=> RDY_N_OE && ARRAY_BLOCK) else $error("no busy");
   a_buf_block: assert property (
      s_take |=> BUF_BLOCK == ($past(OP_BUF) ? 2'h2 : 2'h1))
      else $error("bad buffer block");
   a_busy_len: assert property (
      s_done |-> bcnt == 22'(elen)) else $error("bad busy length");
   a_cmp_flag: assert property (
      s_done ##0 kq == sfc_pkg::OP_CMP |->
      ##1 STATUS_BYTE[6] == $past(CMP_MISMATCH, 2)) else $error("bad comp");
   a_ready_bit: assert property (
      calm == 3'h7 |-> STATUS_BYTE[7] == !$past(RDY_N_OE))
      else $error("bad ready bit");
   a_density_code: assert property (
      calm == 3'h7 |-> STATUS_BYTE[5:0] == {DENSITY_CODE, 3'h0})
      else $error("bad density");
   a_mode_pick: assert property (
      $fell(CS_N) ##0 calm == 3'h7 |-> ##6 MODE3 == $past(SCK, 6))
      else $error("bad mode");
endmodule : sfc_status_monitor
bind sfc_status sfc_status_monitor #(.XFER_CYC(XFER_CYC), .EP_CYC(EP_CYC),
   .P_CYC(P_CYC), .DENSITY_CODE(DENSITY_CODE)) i_mon (.MCLK(MCLK),
   .RST(RST), .RESET_N(RESET_N), .CS_N(CS_N), .SCK(SCK),
   .RDY_N_OE(RDY_N_OE), .OP_START(OP_START), .OP_KIND(OP_KIND),
   .OP_BUF(OP_BUF), .CMP_MISMATCH(CMP_MISMATCH), .OP_ACCEPT(OP_ACCEPT),
   .ARRAY_BLOCK(ARRAY_BLOCK), .BUF_BLOCK(BUF_BLOCK), .MODE3(MODE3),
   .STATUS_BYTE(STATUS_BYTE));

// ---- verification/sfc_host_model.sv ----
`timescale 1ns/1ps
module sfc_host_model (
   output logic cs_n,
   output logic sck,
   output logic si,
   input wire logic so
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b1;
      si = 1'b1;
   end
   // The clock stands at its idle level outside frames.
   task automatic frame(input logic m3, input logic [7:0] opc,
         output logic [8:0] rx);
      // Pin changes sit off the core clock grid, so none races a sample.
      #0.25 sck = m3;
      #64 cs_n = 1'b0;
      #32;
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = opc[i];
         #32 sck = 1'b1;
         #32;
      end
      // Bits after the opcode carry the reserved address bits as zero.
      si = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         sck = 1'b0;
         #32 rx[i] = so;
         sck = 1'b1;
         #32;
      end
      sck = m3;
      #32 cs_n = 1'b1;
      // Wait out the synchroniser so the output is released on return.
      #31.75;
   endtask : frame
   // Moves select alone, with no clocking, to hold it across a reset.
   task automatic hold_cs(input logic lvl);
      #0.25 cs_n = lvl;
   endtask : hold_cs
endmodule : sfc_host_model

// ---- verification/test_serial_flash_ctrl_status.sv ----
`timescale 1ns/1ps
module test_serial_flash_ctrl_status;
   localparam int XC = 20;
   localparam int EC = 400;
   localparam int PC = 300;
   localparam logic [2:0] DC = 3'h5;
   logic mclk = 1'b0, rst = 1'b1, reset_n = 1'b1, op_start = 1'b0;
   logic op_buf = 1'b0, cmp_mm = 1'b0, so_last = 1'b0;
   logic cs_n, sck, si, so_o, so_oe, rdy_o, rdy_oe, acc, ablk, mode3;
   logic exp_cmp = 1'b0;
   sfc_pkg::sfc_op_e op_kind = sfc_pkg::OP_XFER;
   logic [1:0] bblk;
   logic [7:0] stat;
   logic [8:0] rx;
   int err_count = 0, n_checks = 0, cyc = 0;
   int n_oe = 0, n_base = 0;
   sfc_status #(.XFER_CYC(XC), .EP_CYC(EC), .P_CYC(PC), .DENSITY_CODE(DC))
   i_dut (.MCLK(mclk), .RST(rst), .RESET_N(reset_n), .CS_N(cs_n),
      .SCK(sck), .SI(si), .SO_O(so_o), .SO_OE(so_oe), .RDY_N_O(rdy_o),
      .RDY_N_OE(rdy_oe), .OP_START(op_start), .OP_KIND(op_kind),
      .OP_BUF(op_buf), .CMP_MISMATCH(cmp_mm), .OP_ACCEPT(acc),
      .ARRAY_BLOCK(ablk), .BUF_BLOCK(bblk), .MODE3(mode3),
      .STATUS_BYTE(stat));
   // A released output shows the inverse of its last bit, never a guess.
   sfc_host_model i_host (.cs_n(cs_n), .sck(sck), .si(si),
      .so(so_oe ? so_o : ~so_last));
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (so_oe) so_last <= so_o;
      if (so_oe) n_oe <= n_oe + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   function automatic logic [7:0] exp_stat(input logic rdy, cm);
      return {rdy, cm, DC, 3'h0};
   endfunction : exp_stat
   function automatic int op_len(input sfc_pkg::sfc_op_e kd);
      return kd == sfc_pkg::OP_ERPG ? EC : kd == sfc_pkg::OP_PROG ? PC : XC;
   endfunction : op_len
   task automatic chk(input string what, input logic [9:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic run_op(input sfc_pkg::sfc_op_e kd, input logic b, mm);
      int n;
      @(posedge mclk);
      op_kind <= kd;
      op_buf <= b;
      cmp_mm <= mm;
      op_start <= 1'b1;
      #1 chk("accept", acc, 1'b1);
      @(posedge mclk);
      op_start <= 1'b0;
      n = 0;
      #1;
      while (rdy_oe === 1'b1 && n < 500) begin
         if (n == 1) begin
            chk("pin", rdy_oe ? rdy_o : 1'b1, 1'b0);
            chk("block", {ablk, bblk}, {1'b1, b, !b});
            chk("ready", stat[7], 1'b0);
         end
         @(posedge mclk);
         #1 n++;
      end
      chk("busy_len", 10'(n), 10'(op_len(kd)));
      if (kd == sfc_pkg::OP_CMP) exp_cmp = mm;
      repeat (2) @(posedge mclk);
      #1 chk("after", {bblk, stat},
         {2'h0, exp_stat(1'b1, exp_cmp)});
   endtask : run_op
   initial begin
      void'($urandom(32'h2999BE7A));
      // The reset hold also stands in for the settling wait after power-up.
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk("reset", {mode3, so_oe, stat},
         {2'h2, exp_stat(1'b1, 1'b0)});
      for (int m = 0; m < 2; m++) begin
         i_host.frame(m[0], sfc_pkg::OPC_STATUS, rx);
         chk("mode", mode3, m[0]);
         chk("read", rx, {exp_stat(1'b1, 1'b0), 1'b1});
      end
      n_base = n_oe;
      i_host.frame(1'b1, 8'($urandom_range(32'h58, 32'hFF)), rx);
      chk("quiet", 10'(n_oe - n_base), 10'h0);
      for (int k = 0; k < 6; k++) begin
         run_op(sfc_pkg::sfc_op_e'(k % 4), 1'($urandom),
            k == 5 || (k != 1 && 1'($urandom)));
      end
      fork
         run_op(sfc_pkg::OP_ERPG, 1'b0, 1'b0);
         begin
            repeat (30) @(posedge mclk);
            i_host.frame(1'b0, sfc_pkg::OPC_STATUS, rx);
         end
      join
      chk("busy_read", rx, {exp_stat(1'b0, exp_cmp), 1'b0});
      // Select falls now and stays low across the pin reset below.
      i_host.hold_cs(1'b0);
      @(posedge mclk);
      op_kind <= sfc_pkg::OP_PROG;
      op_start <= 1'b1;
      @(posedge mclk);
      op_start <= 1'b0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      op_start <= 1'b1;
      #1 chk("abort", {rdy_oe, ablk}, 2'h0);
      @(posedge mclk);
      op_start <= 1'b0;
      repeat (20) @(posedge mclk);
      #1 chk("held", rdy_oe, 1'b0);
      @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      exp_cmp = 1'b0;
      #1 chk("resume", {mode3, stat},
         {1'b1, exp_stat(1'b1, 1'b0)});
      // Select has not fallen since the reset, so the opcode is ignored.
      n_base = n_oe;
      i_host.frame(1'b1, sfc_pkg::OPC_STATUS, rx);
      chk("unarmed", 10'(n_oe - n_base), 10'h0);
      run_op(sfc_pkg::OP_XFER, 1'b1, 1'b0);
      i_host.frame(1'b0, sfc_pkg::OPC_STATUS, rx);
      chk("rearm", rx, {exp_stat(1'b1, 1'b0), 1'b1});
      tally_and_finish();
   end
endmodule : test_serial_flash_ctrl_status
